// >>> src/ssmsel_pkg.sv
// Shared constants and types for the safe stop method selector.
package ssmsel_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing. The control tick is the unit of every time input.
  localparam int CLK_PERIOD_NS = 40;
  localparam int CTRL_TICK_NS  = 100000;
  localparam int TICK_CYC      = (CTRL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, values after reset and terminal values.
  localparam int              TW          = 16;
  localparam int              SW          = 16;
  localparam int              AW          = 32;
  localparam logic [TW-1:0]   ELAPSED_RST = 16'h0000;
  localparam logic [TW-1:0]   ELAPSED_MAX = 16'hFFFF;
  localparam logic [SW-1:0]   SPEED_RST   = 16'h0000;
  localparam logic [AW-1:0]   ACC_RST     = 32'h0000_0000;
  localparam logic [11:0]     DIV_RST     = 12'h000;
  localparam logic [11:0]     DIV_LAST    = 12'(TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Braking methods and sequencer states.
  typedef enum logic [1:0] {
    M_DYNAMIC_BRAKE_STOP,
    M_ELECTRONIC_BRAKE_STOP,
    M_FORCED_DECEL_STOP
  } ssmsel_method_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BRAKING,
    ST_HOLD,
    ST_TORQUE_OFF
  } ssmsel_state_t;

  // Static configuration bits.
  typedef struct packed {
    logic forced_decel_enable_sel;
    logic electronic_brake_selection;
    logic motor_supported;
    logic torque_mode;
    logic cont_to_torque;
    logic decel_monitor_en;
  } ssmsel_cfg_t;

  // Time settings, all in control ticks.
  typedef struct packed {
    logic [TW-1:0] monitored_stop_time;
    logic [TW-1:0] forced_decel_time_const;
    logic [TW-1:0] brake_sequence_delay;
    logic [TW-1:0] electronic_brake_on_time;
    logic [TW-1:0] decel_monitor_time_const;
  } ssmsel_times_t;

endpackage : ssmsel_pkg

// >>> src/ssmsel_ramp.sv
`timescale 1ns/100ps
`default_nettype none
// Linear speed ramp towards zero. The time constant is the number of control
// ticks needed to fall from the rated speed to zero.
module ssmsel_ramp #(
  parameter int W     = 16,
  parameter int RATED = 3000
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      tick,
  input  wire logic                      load,
  input  wire logic [W-1:0]              init_speed,
  input  wire logic [ssmsel_pkg::TW-1:0] tc,
  output logic      [W-1:0]              speed_r,
  output logic                           done
);
  import ssmsel_pkg::*;

  logic [AW-1:0] acc_r;
  logic          step;

  ////////////////////////////////////////////////////////////////////////////
  // One unit is taken off per clock while the accumulator holds a full time
  // constant, so a tick's share is spread over the following clocks.
  assign step = (acc_r >= AW'(tc)) && (speed_r != SPEED_RST);
  assign done = (speed_r == SPEED_RST);

  // Accumulator and speed; a zero time constant drops the ramp at once.
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r   <= ACC_RST;
      speed_r <= SPEED_RST;
    end else if (load) begin
      acc_r   <= ACC_RST;
      speed_r <= init_speed;
    end else if (done || tc == ELAPSED_RST) begin
      acc_r   <= ACC_RST;
      speed_r <= SPEED_RST;
    end else begin
      acc_r   <= acc_r + (tick ? AW'(RATED) : ACC_RST) - (step ? AW'(tc) : ACC_RST);
      speed_r <= step ? speed_r - W'(1) : speed_r;
    end
  end

  ramp_monotone_a: assert property (@(posedge clk) disable iff (rst)
    !load |=> speed_r <= $past(speed_r))
    else $error("Ramp rose without a load.");

endmodule : ssmsel_ramp
`default_nettype wire

// >>> src/ssmsel_top.sv
`timescale 1ns/100ps
`default_nettype none
//
// Behaviour
// - Request input low starts braking, later torque off.
// - Method from setting, selection, motor, mode, cause.
// - Three methods: dynamic, electronic, forced deceleration.
// - Torque mode or decel off: electronic or dynamic.
// - Otherwise request/decel alarms decelerate, others brake.
// - Continuous-to-torque counts as torque control mode.
// - Forced deceleration ramps with its time constant.
// - Ramp done, below zero speed: base off, delay.
// - Monitor time expiry forces torque off mid-ramp.
// - Observation speed exceeded under deceleration: torque off.
// - Dynamic method engages the dynamic brake immediately.
// - Observation exceeded under dynamic braking raises alarm.
// - Electronic braking hands over after its operating time.
// - Shorter monitor time hands over at that time.
//
module ssmsel_top #(
  parameter int RATED_SPEED = 3000,
  parameter int OBS_OFFSET  = 0
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      stop_req_n,
  input  wire logic                      alarm_stop,
  input  wire logic                      alarm_edb_method,
  input  wire ssmsel_pkg::ssmsel_cfg_t   cfg,
  input  wire ssmsel_pkg::ssmsel_times_t times,
  input  wire logic [ssmsel_pkg::SW-1:0] speed_fb,
  input  wire logic [ssmsel_pkg::SW-1:0] zero_speed_threshold,
  output ssmsel_pkg::ssmsel_method_t     method_r,
  output logic                           stop_active_r,
  output logic                           base_drive_on_r,
  output logic                           decel_active_r,
  output logic                           electronic_brake_on_r,
  output logic                           dyn_brake_on_r,
  output logic                           torque_off_r,
  output logic                           monitor_alarm_r,
  output logic      [ssmsel_pkg::SW-1:0] speed_cmd_r
);
  import ssmsel_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Method choice. The electronic brake only exists on supported motors with
  // automatic selection; every other non-decelerating case falls back to the
  // dynamic brake, which coasts the motor when no brake hardware is fitted.
  function automatic ssmsel_method_t sel_method(
    input ssmsel_cfg_t c,
    input logic        from_alarm,
    input logic        edb_type
  );
    ssmsel_method_t brake;
    logic           torque_like;
    brake = (c.electronic_brake_selection && c.motor_supported) ?
            M_ELECTRONIC_BRAKE_STOP : M_DYNAMIC_BRAKE_STOP;
    torque_like = c.torque_mode || c.cont_to_torque;
    if (!c.forced_decel_enable_sel || torque_like) begin
      sel_method = brake;
    end else if (from_alarm && edb_type) begin
      sel_method = brake;
    end else begin
      sel_method = M_FORCED_DECEL_STOP;
    end
  endfunction : sel_method

  ssmsel_state_t  state_r;
  ssmsel_method_t method_sel;
  logic           act;
  logic           from_alarm;
  logic [11:0]    div_r;
  logic           tick_r;
  logic [TW-1:0]  elapsed_r;
  logic [TW-1:0]  hold_start_r;
  logic           start;
  logic           ramp_done;
  logic [SW-1:0]  obs_speed;
  logic [SW-1:0]  obs_init;
  logic           obs_exceed;
  logic           mst_over;
  logic           go_off;

  ////////////////////////////////////////////////////////////////////////////
  // Activation. A request from the input outranks a concurrent alarm, so the
  // cause is taken as alarm only while the request input is still high.
  assign act        = !stop_req_n || alarm_stop;
  assign from_alarm = alarm_stop && stop_req_n;
  assign method_sel = sel_method(cfg, from_alarm, alarm_edb_method);
  assign start      = (state_r == ST_IDLE) && act;

  // Control tick divider.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r  <= DIV_RST;
      tick_r <= 1'b0;
    end else begin
      div_r  <= (div_r == DIV_LAST) ? DIV_RST : div_r + 12'h001;
      tick_r <= (div_r == DIV_LAST);
    end
  end

  // Elapsed time since activation, saturating, held at zero while idle.
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE) begin
      elapsed_r <= ELAPSED_RST;
    end else if (tick_r && elapsed_r != ELAPSED_MAX) begin
      elapsed_r <= elapsed_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed command ramp and observation-speed ramp share one ramp design; the
  // observation starts from the feedback caught at activation plus offset.
  assign obs_init = speed_fb + SW'(OBS_OFFSET);

  ssmsel_ramp #(
    .W     (SW),
    .RATED (RATED_SPEED)
  ) u_cmd_ramp (
    .clk        (clk),
    .rst        (rst),
    .tick       (tick_r),
    .load       (start),
    .init_speed (speed_fb),
    .tc         (times.forced_decel_time_const),
    .speed_r    (speed_cmd_r),
    .done       (ramp_done)
  );

  ssmsel_ramp #(
    .W     (SW),
    .RATED (RATED_SPEED)
  ) u_obs_ramp (
    .clk        (clk),
    .rst        (rst),
    .tick       (tick_r),
    .load       (start),
    .init_speed (obs_init),
    .tc         (times.decel_monitor_time_const),
    .speed_r    (obs_speed),
    .done       ()
  );

  // Monitor expiry, judged while braking or holding, and observation excess, judged only while braking.
  assign obs_exceed = cfg.decel_monitor_en && (state_r == ST_BRAKING) && (speed_fb > obs_speed);
  assign mst_over   = (elapsed_r >= times.monitored_stop_time);
  assign go_off     = act && (state_r == ST_BRAKING || state_r == ST_HOLD) &&
                      (mst_over || (method_r == M_FORCED_DECEL_STOP && obs_exceed));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Releasing both the request and the alarm returns to idle from any state; the
  // power-stage outputs go back to normal one clock after the state does.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r               <= ST_IDLE;
      method_r              <= M_DYNAMIC_BRAKE_STOP;
      stop_active_r         <= 1'b0;
      base_drive_on_r       <= 1'b0;
      decel_active_r        <= 1'b0;
      electronic_brake_on_r <= 1'b0;
      dyn_brake_on_r        <= 1'b0;
      torque_off_r          <= 1'b0;
      hold_start_r          <= ELAPSED_RST;
    end else if (!act && state_r != ST_IDLE) begin
      state_r <= ST_IDLE;
    end else if (go_off) begin
      state_r               <= ST_TORQUE_OFF;
      torque_off_r          <= 1'b1;
      base_drive_on_r       <= 1'b0;
      decel_active_r        <= 1'b0;
      electronic_brake_on_r <= 1'b0;
      dyn_brake_on_r        <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          stop_active_r         <= act;
          base_drive_on_r       <= 1'b1;
          decel_active_r        <= 1'b0;
          electronic_brake_on_r <= 1'b0;
          dyn_brake_on_r        <= 1'b0;
          torque_off_r          <= 1'b0;
          if (act) begin
            state_r  <= ST_BRAKING;
            method_r <= method_sel;
            case (method_sel)
              M_DYNAMIC_BRAKE_STOP: begin
                dyn_brake_on_r  <= 1'b1;
                base_drive_on_r <= 1'b0;
              end
              M_ELECTRONIC_BRAKE_STOP: begin
                electronic_brake_on_r <= 1'b1;
              end
              default: begin
                decel_active_r <= 1'b1;
              end
            endcase
          end
        end
        ST_BRAKING: begin
          if (method_r == M_FORCED_DECEL_STOP && ramp_done &&
              speed_fb <= zero_speed_threshold) begin
            base_drive_on_r <= 1'b0;
            decel_active_r  <= 1'b0;
            hold_start_r    <= elapsed_r;
            state_r         <= ST_HOLD;
          end else if (method_r == M_ELECTRONIC_BRAKE_STOP &&
                       elapsed_r >= times.electronic_brake_on_time) begin
            electronic_brake_on_r <= 1'b0;
            dyn_brake_on_r        <= 1'b1;
            base_drive_on_r       <= 1'b0;
            hold_start_r          <= elapsed_r;
            state_r               <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // The delay runs on the shared elapsed count, not a private timer.
          if (elapsed_r - hold_start_r >= times.brake_sequence_delay) begin
            dyn_brake_on_r <= 1'b1;
          end
        end
        ST_TORQUE_OFF: begin
          torque_off_r <= 1'b1;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Excess under dynamic braking cannot slow the motor any further, so it is
  // flagged as an alarm instead; the flag stays until the stop is released.
  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_alarm_r <= 1'b0;
    end else if (act && obs_exceed && method_r == M_DYNAMIC_BRAKE_STOP) begin
      monitor_alarm_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      monitor_alarm_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking ssmsel_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  stop_expiry_a: assert property (
    (state_r == ST_BRAKING) && act && mst_over |=> torque_off_r && dyn_brake_on_r)
    else $error("Monitor time expired without torque off.");

  brake_immediate_a: assert property (
    start && method_sel == M_DYNAMIC_BRAKE_STOP |=> dyn_brake_on_r && !base_drive_on_r)
    else $error("Dynamic method did not brake at once.");

  torque_method_a: assert property (
    start && (cfg.torque_mode || cfg.cont_to_torque) |=> method_r != M_FORCED_DECEL_STOP)
    else $error("Torque mode chose forced deceleration.");

  decel_method_a: assert property (
    start && cfg.forced_decel_enable_sel && !cfg.torque_mode && !cfg.cont_to_torque &&
    !stop_req_n |=> method_r == M_FORCED_DECEL_STOP && decel_active_r)
    else $error("Request stop did not decelerate.");

  edb_handover_a: assert property (
    (state_r == ST_BRAKING) && act && !mst_over && method_r == M_ELECTRONIC_BRAKE_STOP &&
    elapsed_r >= times.electronic_brake_on_time |=> dyn_brake_on_r && !electronic_brake_on_r)
    else $error("Electronic braking did not hand over.");

  base_cutoff_a: assert property (
    (state_r == ST_BRAKING) && act && !go_off && method_r == M_FORCED_DECEL_STOP &&
    ramp_done && speed_fb <= zero_speed_threshold |=> !base_drive_on_r ##0 state_r == ST_HOLD)
    else $error("Base drive not cut after ramp end.");

  hold_delay_a: assert property (
    (state_r == ST_HOLD) && act && !go_off &&
    elapsed_r - hold_start_r >= times.brake_sequence_delay |=> dyn_brake_on_r)
    else $error("Dynamic brake late after sequence delay.");

  obs_cutoff_a: assert property (
    act && obs_exceed && method_r == M_FORCED_DECEL_STOP |=> torque_off_r)
    else $error("Observation excess did not cut torque.");

  obs_alarm_a: assert property (
    act && obs_exceed && method_r == M_DYNAMIC_BRAKE_STOP |=> monitor_alarm_r [*1])
    else $error("Observation excess under dynamic brake gave no alarm.");

  elapsed_step_a: assert property (
    state_r != ST_IDLE && tick_r && elapsed_r != ELAPSED_MAX |=>
    elapsed_r == $past(elapsed_r) + 16'h0001)
    else $error("Elapsed count missed a tick.");

  torque_off_brake_a: assert property (
    torque_off_r |-> dyn_brake_on_r && !base_drive_on_r)
    else $error("Torque off without dynamic brake.");

endmodule : ssmsel_top
`default_nettype wire

// >>> verification/ssmsel_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
// Motor and power stage seen from the selector. Speed tracks the ramp while
// it runs and bleeds off slowly under either brake, so a tight monitoring
// constant can really be overrun.
module ssmsel_motor_model (
  input  wire logic        clk,
  input  wire logic        preset,
  input  wire logic [15:0] preset_val,
  input  wire logic        decel_active,
  input  wire logic [15:0] speed_cmd,
  input  wire logic        brake_on,
  output logic      [15:0] speed_r
);
  logic [3:0] div_r = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // One unit of speed is lost every sixteen clocks while braked. A plain
  // always keeps the declaration value of the divider legal.
  always @(posedge clk) begin
    div_r <= div_r + 4'h1;
    if (preset) begin
      speed_r <= preset_val;
    end else if (decel_active) begin
      speed_r <= speed_cmd;
    end else if (brake_on && div_r == 4'h0 && speed_r != 16'h0000) begin
      speed_r <= speed_r - 16'h0001;
    end
  end
endmodule : ssmsel_motor_model
`default_nettype wire

// >>> verification/tb_safe_stop_method_select.sv
`timescale 1ns/100ps
`default_nettype none
module tb_safe_stop_method_select;
  import ssmsel_pkg::*;
  logic           clk = 1'b0;
  logic           rst;
  logic           stop_req_n;
  logic           alarm_stop;
  logic           alarm_edb_method;
  ssmsel_cfg_t    cfg;
  ssmsel_times_t  times;
  logic [15:0]    speed_fb;
  logic [15:0]    zero_speed_threshold;
  logic           preset;
  logic [15:0]    preset_val;
  ssmsel_method_t method_r;
  logic           stop_active_r;
  logic           base_drive_on_r;
  logic           decel_active_r;
  logic           electronic_brake_on_r;
  logic           dyn_brake_on_r;
  logic           torque_off_r;
  logic           monitor_alarm_r;
  logic [15:0]    speed_cmd_r;
  int             err_count = 0;
  int             samples_checked = 0;

  // Free running 25 MHz clock.
  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // A small observation offset absorbs the one-clock lag of the motor model.
  ssmsel_top #(
    .OBS_OFFSET (16)
  ) u_dut (
    .clk(clk), .rst(rst), .stop_req_n(stop_req_n), .alarm_stop(alarm_stop),
    .alarm_edb_method(alarm_edb_method), .cfg(cfg), .times(times),
    .speed_fb(speed_fb), .zero_speed_threshold(zero_speed_threshold),
    .method_r(method_r), .stop_active_r(stop_active_r),
    .base_drive_on_r(base_drive_on_r), .decel_active_r(decel_active_r),
    .electronic_brake_on_r(electronic_brake_on_r), .dyn_brake_on_r(dyn_brake_on_r),
    .torque_off_r(torque_off_r), .monitor_alarm_r(monitor_alarm_r),
    .speed_cmd_r(speed_cmd_r)
  );

  ssmsel_motor_model u_motor (
    .clk(clk), .preset(preset), .preset_val(preset_val),
    .decel_active(decel_active_r), .speed_cmd(speed_cmd_r),
    .brake_on(dyn_brake_on_r | electronic_brake_on_r), .speed_r(speed_fb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison helpers; case inequality so an unknown never matches.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chkb

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  function automatic logic sig(input int s);
    case (s)
      0: return !base_drive_on_r;
      1: return dyn_brake_on_r;
      2: return torque_off_r;
      default: return monitor_alarm_r;
    endcase
  endfunction : sig

  // Bounded wait for an event output, so a missing event cannot hang the run.
  task automatic wait_on(input int s, input int lim);
    int n;
    n = 0;
    while (sig(s) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    chkb("event_seen", 1'b1, sig(s));
  endtask : wait_on

  // Brake sequence delay is fixed at two ticks in every scenario.
  task automatic setup(input logic [5:0] c, input logic [15:0] mon, input logic [15:0] tc,
                       input logic [15:0] eb, input logic [15:0] dmon, input logic [15:0] spd);
    @(posedge clk);
    cfg        <= ssmsel_cfg_t'(c);
    times      <= {mon, tc, 16'h0002, eb, dmon};
    preset     <= 1'b1;
    preset_val <= spd;
    @(posedge clk);
    preset <= 1'b0;
  endtask : setup

  task automatic start(input logic req, input logic alm, input logic edb);
    @(posedge clk);
    stop_req_n       <= !req;
    alarm_stop       <= alm;
    alarm_edb_method <= edb;
    #1;
  endtask : start

  task automatic stop_all;
    @(posedge clk);
    stop_req_n <= 1'b1;
    alarm_stop <= 1'b0;
    cyc(3);
    chkb("base_on", 1'b1, base_drive_on_r);
    chkb("torque_off", 1'b0, torque_off_r);
    chkb("dyn_brake", 1'b0, dyn_brake_on_r);
    chkb("alarm", 1'b0, monitor_alarm_r);
  endtask : stop_all

  ////////////////////////////////////////////////////////////////////////////
  // Every combination of the five method settings, monitoring off, against all three activation causes.
  task automatic method_table;
    logic [5:0]     c;
    ssmsel_method_t e;
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 3; k++) begin
        c = {5'(i), 1'b0};
        setup(c, 16'h0028, 16'h0014, 16'h0014, 16'h0014, 16'h0258);
        e = (c[4] && c[3]) ? M_ELECTRONIC_BRAKE_STOP : M_DYNAMIC_BRAKE_STOP;
        if (c[5] && !c[2] && !c[1] && k != 2) begin
          e = M_FORCED_DECEL_STOP;
        end
        start(k == 0, k != 0, k == 2);
        cyc(2);
        chk("method", 16'(e), 16'(method_r));
        chkb("dyn", e == M_DYNAMIC_BRAKE_STOP, dyn_brake_on_r);
        chkb("elec", e == M_ELECTRONIC_BRAKE_STOP, electronic_brake_on_r);
        chkb("decel", e == M_FORCED_DECEL_STOP, decel_active_r);
        chkb("stop_active", 1'b1, stop_active_r);
        stop_all;
      end
    end
  endtask : method_table

  // Monitoring on with a slow observation constant must not cut torque.
  task automatic decel_seq;
    setup(6'h21, 16'h0014, 16'h0001, 16'h0014, 16'h0014, 16'h012C);
    start(1'b1, 1'b0, 1'b0);
    wait_on(0, 8000);
    chk("speed_cmd", 16'h0000, speed_cmd_r);
    chkb("dyn_early", 1'b0, dyn_brake_on_r);
    cyc(TICK_CYC - 100);
    chkb("dyn_delay", 1'b0, dyn_brake_on_r);
    wait_on(1, TICK_CYC + 200);
    chkb("torque_off", 1'b0, torque_off_r);
    stop_all;
  endtask : decel_seq

  // Slow ramp, short monitor time: torque off arrives mid-ramp.
  task automatic expire;
    setup(6'h20, 16'h0003, 16'h03E8, 16'h0014, 16'h0014, 16'h0258);
    start(1'b1, 1'b0, 1'b0);
    cyc(2 * TICK_CYC - 100);
    chkb("torque_early", 1'b0, torque_off_r);
    wait_on(2, TICK_CYC + 200);
    chkb("dyn", 1'b1, dyn_brake_on_r);
    chkb("ramp_mid", 1'b1, speed_cmd_r != 16'h0000);
    stop_all;
  endtask : expire

  task automatic obs_excess;
    setup(6'h21, 16'h0028, 16'h0014, 16'h0014, 16'h0002, 16'h0258);
    start(1'b0, 1'b1, 1'b0);
    wait_on(2, 4 * TICK_CYC);
    chkb("alarm", 1'b0, monitor_alarm_r);
    stop_all;
  endtask : obs_excess

  task automatic db_alarm;
    setup(6'h01, 16'h0028, 16'h0014, 16'h0014, 16'h0001, 16'h0258);
    start(1'b0, 1'b1, 1'b1);
    wait_on(3, 4 * TICK_CYC);
    chkb("torque_off", 1'b0, torque_off_r);
    chkb("dyn", 1'b1, dyn_brake_on_r);
    stop_all;
  endtask : db_alarm

  // Hand-over happens at the shorter of operating time and monitor time.
  task automatic edb(input int eb, input int mon);
    int t;
    t = (mon < eb) ? mon : eb;
    setup(6'h18, 16'(mon), 16'h0014, 16'(eb), 16'h0014, 16'h0258);
    start(1'b1, 1'b0, 1'b0);
    if (t > 1) begin
      cyc(TICK_CYC * (t - 1) - 100);
      chkb("elec_held", 1'b1, electronic_brake_on_r);
      chkb("dyn_held", 1'b0, dyn_brake_on_r);
    end
    wait_on(1, TICK_CYC + 200);
    chkb("torque_off", mon <= eb, torque_off_r);
    chkb("base", 1'b0, base_drive_on_r);
    stop_all;
  endtask : edb

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("Checks %0d, errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Monitor times are long enough for each motor to stop, except in expire and edb(6, 1), which cut torque first.
  initial begin
    rst = 1'b1;
    stop_req_n = 1'b1;
    alarm_stop = 1'b0;
    alarm_edb_method = 1'b0;
    cfg = '0;
    times = '0;
    zero_speed_threshold = 16'h000A;
    preset = 1'b0;
    preset_val = 16'h0000;
    cyc(16);
    chkb("reset_base", 1'b0, base_drive_on_r);
    @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chkb("base_after_reset", 1'b1, base_drive_on_r);
    method_table;
    decel_seq;
    expire;
    obs_excess;
    db_alarm;
    edb(2, 8);
    edb(6, 1);
    conclude;
  end

  // The scenarios need about 27500 clocks; a hang is cut off at 90000.
  initial begin
    #(32'h0001_5F90 * CLK_PERIOD_NS);
    err_count++;
    $display("ERROR watchdog expected finish seen hang");
    conclude;
  end
endmodule : tb_safe_stop_method_select
`default_nettype wire
